// >>> design/eep_mem.sv
// cell array: write port on the core clock, registered read on the serial clock
`timescale 1ns/1ns
module eep_mem #(
  parameter int DEPTH = 512,
  parameter int AW = 9
)(
  input wire logic wr_clk,
  input wire logic rd_clk,
  eep_mem_if.mem port
);
  logic [7:0] cells [DEPTH];

  // refuse an array that the address cannot reach
  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_bad_depth
    $error("eep_mem depth does not fit address width");
  end

  // nonvolatile write from the self-timed cycle
  always_ff @(posedge wr_clk)
  begin
    if (port.wr_en)
    begin
      cells[port.wr_addr] <= port.wr_data;
    end
  end

  // read data comes out of a register
  always_ff @(posedge rd_clk)
  begin
    port.rd_data <= cells[port.rd_addr];
  end
endmodule // eep_mem

// >>> design/eep_mem_if.sv
// memory port bundle between the slave logic and its cell array
`timescale 1ns/1ns
interface eep_mem_if #(parameter int AW = 9);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// >>> design/eep_pkg.sv
// types of the serial eeprom slave: state enums and state records
package eep_pkg;
  typedef enum logic [2:0] {
    EEP_LINK_IDLE = 3'b000,
    EEP_LINK_SEL = 3'b001,
    EEP_LINK_ADDR = 3'b010,
    EEP_LINK_WDATA = 3'b011,
    EEP_LINK_RDATA = 3'b100
  } eep_link_e;

  typedef enum logic [1:0] {
    EEP_CORE_IDLE = 2'b00,
    EEP_CORE_COPY = 2'b01,
    EEP_CORE_WAIT = 2'b10
  } eep_core_e;

  typedef struct packed {
    eep_link_e state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [8:0] addr;
    logic a8;
    logic prot;
    logic ack;
    logic pend;
    logic [15:0] mask;
    logic [15:0][7:0] page;
    logic start_seen;
    logic stop_seen;
  } eep_link_s;

  typedef struct packed {
    eep_core_e state;
    logic [3:0] idx;
    logic [31:0] cnt;
    logic req_seen;
    logic done_tog;
    logic busy;
  } eep_core_s;
endpackage

// >>> design/eep_regs.svh
// constants of the serial eeprom slave: geometry, select fields, timing
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH
`define EEP_MEM_DEPTH 512
`define EEP_ADDR_W 9
`define EEP_PAGE_BYTES 16
`define EEP_SEL_RW_BIT 0
`define EEP_SEL_A8_BIT 1
`define EEP_SEL_CS_LO_BIT 2
`define EEP_SEL_CS_HI_BIT 3
`define EEP_SEL_TYPE_LSB 4
`define EEP_UPPER_BASE 9'h100
`define EEP_ADDR_RESET 9'h000
`define EEP_ACK_SLOT 4'h8
`define EEP_LAST_BIT 4'h7
`define EEP_WRITE_TIME_US 50
`define EEP_CORE_CLK_KHZ 20000
`define EEP_WRITE_CYCLES ((`EEP_WRITE_TIME_US * `EEP_CORE_CLK_KHZ) / 1000)
`endif

// >>> design/eep_top.sv
// serial eeprom slave front end: bus protocol, page latch, timed write
`timescale 1ns/1ns
`include "eep_regs.svh"
module eep_top #(
  parameter logic [3:0] DEV_TYPE = 4'hC, // arbitrary type code
  parameter int WRITE_CYCLES = `EEP_WRITE_CYCLES
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda,
  output logic sda_drive,
  output logic sda_drive_en,
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic upper_half_write_guard,
  output logic write_busy
);
  eep_pkg::eep_link_s lnk_q;
  eep_pkg::eep_link_s lnk_d;
  eep_pkg::eep_core_s core_q;
  eep_pkg::eep_core_s core_d;
  logic start_tog_q;
  logic stop_tog_q;
  logic wr_req_tog_q;
  logic wr_armed;
  logic busy_lnk;
  logic sel_match;
  logic [7:0] byte_in;
  logic [3:0] lnk_raw;
  wire [3:0] lnk_sync;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic req_sync_q;

  // refuse a write time the counter cannot serve
  if (WRITE_CYCLES < 1)
  begin : g_bad_write
    $error("eep_top write cycle count must be at least one");
  end

  eep_mem_if #(.AW(`EEP_ADDR_W)) mem_bus ();

  // cell array, 512 by 8
  eep_mem #(
    .DEPTH(`EEP_MEM_DEPTH),
    .AW(`EEP_ADDR_W)
  ) u_mem (
    .wr_clk(core_clk),
    .rd_clk(scl_clk),
    .port(mem_bus.mem)
  );

  // pins and the core toggle into the serial domain: strap low, strap high, guard, done
  assign lnk_raw = {core_q.done_tog, upper_half_write_guard, chip_select_strap_high, chip_select_strap_low};

  // three stages per bit, value taken once stages two and three agree
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_lnk_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic stable_q;
      always_ff @(posedge scl_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          stable_q <= 1'b0;
        end
        else
        begin
          s1_q <= lnk_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
          begin
            stable_q <= s3_q; // a floating guard never agrees on one, reads low
          end
        end
      end
      assign lnk_sync[g] = stable_q;
    end
  endgenerate

  // start: data falls while the clock is high
  always_ff @(negedge sda or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_tog_q <= 1'b0;
    end
    else if (scl_clk)
    begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // stop: data rises while the clock is high; arms the write only in the tenth slot
  always_ff @(posedge sda or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_tog_q <= 1'b0;
      wr_req_tog_q <= 1'b0;
    end
    else if (scl_clk)
    begin
      stop_tog_q <= ~stop_tog_q;
      if (wr_armed)
      begin
        wr_req_tog_q <= ~wr_req_tog_q;
      end
    end
  end

  // tenth slot: one clock after the ack of a stored data byte
  assign wr_armed = (lnk_q.state == eep_pkg::EEP_LINK_WDATA) && (lnk_q.cnt == 4'h1) && lnk_q.pend;
  // write request outstanding until the core returns its done toggle
  assign busy_lnk = wr_req_tog_q != lnk_sync[3];
  assign byte_in = {lnk_q.shreg[6:0], sda};
  // type code and both straps must match
  assign sel_match = (byte_in[7:`EEP_SEL_TYPE_LSB] == DEV_TYPE)
    && (byte_in[`EEP_SEL_CS_HI_BIT] == lnk_sync[1])
    && (byte_in[`EEP_SEL_CS_LO_BIT] == lnk_sync[0]);

  // protocol engine, bits sampled on the rising serial clock
  always_comb
  begin
    lnk_d = lnk_q;
    if (busy_lnk)
    begin
      // ignore the bus, swallow any start or stop seen meanwhile
      lnk_d.state = eep_pkg::EEP_LINK_IDLE;
      lnk_d.ack = 1'b0;
      lnk_d.start_seen = start_tog_q;
      lnk_d.stop_seen = stop_tog_q;
    end
    else if (lnk_q.start_seen != start_tog_q)
    begin
      // first select bit arrives on the edge after a start
      lnk_d.start_seen = start_tog_q;
      lnk_d.stop_seen = stop_tog_q;
      lnk_d.state = eep_pkg::EEP_LINK_SEL;
      lnk_d.shreg = {7'h00, sda};
      lnk_d.cnt = 4'h1;
      lnk_d.ack = 1'b0;
    end
    else if (lnk_q.stop_seen != stop_tog_q)
    begin
      lnk_d.stop_seen = stop_tog_q;
      lnk_d.state = eep_pkg::EEP_LINK_IDLE;
      lnk_d.ack = 1'b0;
    end
    else
    begin
      case (lnk_q.state)
        eep_pkg::EEP_LINK_SEL:
        begin
          if (lnk_q.cnt != `EEP_ACK_SLOT)
          begin
            lnk_d.shreg = byte_in;
            lnk_d.cnt = lnk_q.cnt + 4'h1;
            if (lnk_q.cnt == `EEP_LAST_BIT)
            begin
              if (sel_match)
              begin
                lnk_d.ack = 1'b1;
                lnk_d.a8 = byte_in[`EEP_SEL_A8_BIT];
              end
              else
              begin
                lnk_d.state = eep_pkg::EEP_LINK_IDLE;
              end
            end
          end
          else
          begin
            lnk_d.cnt = 4'h0;
            lnk_d.ack = 1'b0;
            if (lnk_q.shreg[`EEP_SEL_RW_BIT])
            begin
              lnk_d.state = eep_pkg::EEP_LINK_RDATA;
            end
            else
            begin
              lnk_d.state = eep_pkg::EEP_LINK_ADDR;
            end
          end
        end
        eep_pkg::EEP_LINK_ADDR:
        begin
          if (lnk_q.cnt != `EEP_ACK_SLOT)
          begin
            lnk_d.shreg = byte_in;
            lnk_d.cnt = lnk_q.cnt + 4'h1;
            if (lnk_q.cnt == `EEP_LAST_BIT)
            begin
              lnk_d.addr = {lnk_q.a8, byte_in};
              lnk_d.prot = lnk_sync[2] && ({lnk_q.a8, byte_in} >= `EEP_UPPER_BASE);
              lnk_d.ack = 1'b1;
              lnk_d.mask = 16'h0000;
              lnk_d.pend = 1'b0;
            end
          end
          else
          begin
            lnk_d.cnt = 4'h0;
            lnk_d.ack = 1'b0;
            lnk_d.state = eep_pkg::EEP_LINK_WDATA;
          end
        end
        eep_pkg::EEP_LINK_WDATA:
        begin
          if (lnk_q.cnt != `EEP_ACK_SLOT)
          begin
            lnk_d.shreg = byte_in;
            lnk_d.cnt = lnk_q.cnt + 4'h1;
            if ((lnk_q.cnt == `EEP_LAST_BIT) && !lnk_q.prot)
            begin
              // latch into the page, step only the low four bits
              lnk_d.page[lnk_q.addr[3:0]] = byte_in;
              lnk_d.mask[lnk_q.addr[3:0]] = 1'b1;
              lnk_d.addr[3:0] = lnk_q.addr[3:0] + 4'h1;
              lnk_d.pend = 1'b1;
              lnk_d.ack = 1'b1;
            end
          end
          else
          begin
            lnk_d.cnt = 4'h0; // guarded bytes leave ack low
            lnk_d.ack = 1'b0;
          end
        end
        eep_pkg::EEP_LINK_RDATA:
        begin
          if (lnk_q.cnt != `EEP_ACK_SLOT)
          begin
            lnk_d.cnt = lnk_q.cnt + 4'h1;
            if (lnk_q.cnt == `EEP_LAST_BIT)
            begin
              lnk_d.addr = lnk_q.addr + 9'h001;
            end
          end
          else if (!sda)
          begin
            lnk_d.cnt = 4'h0;
          end
          else
          begin
            lnk_d.state = eep_pkg::EEP_LINK_IDLE;
          end
        end
        default:
        begin
          lnk_d.state = eep_pkg::EEP_LINK_IDLE;
          lnk_d.ack = 1'b0;
        end
      endcase
    end
  end

  // serial domain state, cleared while reset holds
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk_q <= '0;
    end
    else
    begin
      lnk_q <= lnk_d;
    end
  end

  // data line changes on the falling clock: ack slot or read bits, pull low only
  always_ff @(negedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_drive_en <= 1'b0;
    end
    else if (busy_lnk)
    begin
      sda_drive_en <= 1'b0;
    end
    else if ((lnk_q.state == eep_pkg::EEP_LINK_RDATA) && (lnk_q.cnt != `EEP_ACK_SLOT))
    begin
      sda_drive_en <= ~mem_bus.rd_data[~lnk_q.cnt[2:0]];
    end
    else
    begin
      sda_drive_en <= lnk_q.ack && (lnk_q.cnt == `EEP_ACK_SLOT);
    end
  end

  // open drain: level is always low, only the enable moves
  assign sda_drive = 1'b0;
  assign mem_bus.rd_addr = lnk_q.addr;

  // write request toggle into the core domain
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      req_sync_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= wr_req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q == req_s3_q)
      begin
        req_sync_q <= req_s3_q;
      end
    end
  end

  // self-timed write: copy marked page bytes, then count out the write time;
  // page latch is frozen by the serial side until the done toggle returns
  always_comb
  begin
    core_d = core_q;
    mem_bus.wr_en = 1'b0;
    mem_bus.wr_addr = {lnk_q.addr[8:4], core_q.idx};
    mem_bus.wr_data = lnk_q.page[core_q.idx];
    case (core_q.state)
      eep_pkg::EEP_CORE_IDLE:
      begin
        if (req_sync_q != core_q.req_seen)
        begin
          core_d.req_seen = req_sync_q;
          core_d.state = eep_pkg::EEP_CORE_COPY;
          core_d.idx = 4'h0;
          core_d.busy = 1'b1;
        end
      end
      eep_pkg::EEP_CORE_COPY:
      begin
        mem_bus.wr_en = lnk_q.mask[core_q.idx];
        core_d.idx = core_q.idx + 4'h1;
        if (core_q.idx == 4'hF)
        begin
          core_d.state = eep_pkg::EEP_CORE_WAIT;
          core_d.cnt = 32'h0000_0000;
        end
      end
      eep_pkg::EEP_CORE_WAIT:
      begin
        core_d.cnt = core_q.cnt + 32'h0000_0001;
        if (core_q.cnt >= 32'(WRITE_CYCLES - 1))
        begin
          core_d.done_tog = ~core_q.done_tog;
          core_d.busy = 1'b0;
          core_d.state = eep_pkg::EEP_CORE_IDLE;
        end
      end
      default:
      begin
        core_d.state = eep_pkg::EEP_CORE_IDLE;
      end
    endcase
  end

  // core domain state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_q <= '0;
    end
    else
    begin
      core_q <= core_d;
    end
  end

  assign write_busy = core_q.busy;
endmodule // eep_top

// >>> verif/eep_master.sv
// bus master model driving serial clock and data, 80 ns bit period
`timescale 1ns/1ns
module eep_master (
  output logic scl_clk = 1'b1,
  output logic pull_low = 1'b0,
  input wire logic line
);
  // one bit out, data moved only while clock low
  task automatic put_bit(input logic b);
    #20 pull_low = !b;
    #20 scl_clk = 1'b1;
    #40 scl_clk = 1'b0;
  endtask
  // one bit in, line released, sampled mid high
  task automatic get_bit(output logic b);
    #20 pull_low = 1'b0;
    #20 scl_clk = 1'b1;
    #20 b = line;
    #20 scl_clk = 1'b0;
  endtask
  // start or repeated start: data falls with clock high
  task automatic start_cond();
    if (!scl_clk)
    begin
      #20 pull_low = 1'b0;
      #20 scl_clk = 1'b1;
    end
    #20 pull_low = 1'b1;
    #20 scl_clk = 1'b0;
  endtask
  // stop in the slot after the ack, clock then stands high
  task automatic stop_cond();
    #20 pull_low = 1'b1;
    #20 scl_clk = 1'b1;
    #20 pull_low = 1'b0;
    #20;
  endtask
  // byte out msb first, ack returned high when answered
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = !ack;
  endtask
  // byte in, then ack to go on or nack to end
  task automatic recv_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!more);
  endtask
endmodule // eep_master

// >>> verif/eep_top_props.sv
// port checker for the serial eeprom slave, bound to its top
`timescale 1ns/1ns
module eep_top_props #(
  parameter int WRITE_CYCLES = 1000
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda,
  input wire logic sda_drive,
  input wire logic sda_drive_en,
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic upper_half_write_guard,
  input wire logic write_busy
);
  logic [15:0] busy_cnt_q;
  logic en_rise_q;
  // length of the current busy run
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= write_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  // drive enable seen at each rising serial clock
  always_ff @(posedge scl_clk or negedge rst_n)
    if (!rst_n)
      en_rise_q <= 1'b0;
    else
      en_rise_q <= sda_drive_en;
  a_drive_never_high: assert property (
    @(posedge core_clk) disable iff (!rst_n) sda_drive == 1'b0)
    else $error("data line driven high");
  a_reset_outputs_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_n) $rose(rst_n) |-> !sda_drive_en && !write_busy)
    else $error("outputs active right after reset");
  a_busy_min_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n) $rose(write_busy) |-> write_busy [*8])
    else $error("write cycle too short");
  a_busy_run_bounded: assert property (
    @(posedge core_clk) disable iff (!rst_n) busy_cnt_q <= 16'(WRITE_CYCLES + 64))
    else $error("write cycle never ends");
  a_busy_full_time: assert property (
    @(posedge core_clk) disable iff (!rst_n) $fell(write_busy) |-> busy_cnt_q >= 16'(WRITE_CYCLES))
    else $error("write cycle shorter than its count");
  a_busy_no_ack: assert property (
    @(posedge core_clk) disable iff (!rst_n) write_busy |-> !sda_drive_en)
    else $error("line pulled during write cycle");
  a_busy_after_stop: assert property (
    @(posedge core_clk) disable iff (!rst_n) $rose(write_busy) |-> scl_clk && sda)
    else $error("write cycle started inside a frame");
  a_drive_low_phase: assert property (
    @(negedge scl_clk) disable iff (!rst_n) sda_drive_en == en_rise_q)
    else $error("data drive changed while clock high");
endmodule // eep_top_props

bind eep_top eep_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda(sda), .sda_drive(sda_drive),
  .sda_drive_en(sda_drive_en), .chip_select_strap_low(chip_select_strap_low),
  .chip_select_strap_high(chip_select_strap_high), .upper_half_write_guard(upper_half_write_guard),
  .write_busy(write_busy));

// >>> verif/eep_top_test.sv
// self-checking bench for the serial eeprom slave front end
`timescale 1ns/1ns
module eep_top_test;
  localparam int WCYC = 20;
  localparam logic [3:0] TYP = 4'hC; // arbitrary type code
  logic core_clk = 1'b0;
  logic rst_n;
  logic cs_lo = 1'b0;
  logic cs_hi = 1'b0;
  logic guard = 1'b0;
  logic scl_clk, pull_low, sda_drive, sda_drive_en, write_busy, ack;
  logic [7:0] rd;
  logic [8:0] base, a;
  logic [7:0] exp_mem [512];
  integer seed = 32'h0000_8364;
  int failures = 0;
  int checked = 0;
  int n;
  // open-drain line with pull-up
  wire sda = !pull_low && (!sda_drive_en || sda_drive);
  always #25 core_clk = !core_clk;
  eep_master m (.scl_clk(scl_clk), .pull_low(pull_low), .line(sda));
  eep_top #(.DEV_TYPE(TYP), .WRITE_CYCLES(WCYC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda(sda), .sda_drive(sda_drive),
    .sda_drive_en(sda_drive_en), .chip_select_strap_low(cs_lo), .chip_select_strap_high(cs_hi),
    .upper_half_write_guard(guard), .write_busy(write_busy));
  // comparison, verdict and bounded waits
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic want_ack(input string what, input logic exp);
    check(what, {7'h00, ack}, {7'h00, exp});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic bound(input int lim);
    if (n >= lim)
    begin
      failures++;
      $display("MISMATCH wait expected done seen timeout");
      tally_and_finish();
    end
  endtask
  // select byte for the strapped device
  function automatic logic [7:0] sel(input logic a8, input logic rw);
    return {TYP, cs_hi, cs_lo, a8, rw};
  endfunction
  // start, write select and address byte
  task automatic open_w(input logic [8:0] adr);
    m.start_cond();
    m.send_byte(sel(adr[8], 1'b0), ack);
    want_ack("select", 1'b1);
    m.send_byte(adr[7:0], ack);
    want_ack("address", 1'b1);
  endtask
  task automatic rd_chk(input logic [8:0] adr, input logic more);
    m.recv_byte(more, rd);
    check("read data", rd, exp_mem[adr]);
  endtask
  // timed write: busy rises, polls nack, then answer again
  task automatic wait_write();
    for (n = 0; n < 200 && write_busy !== 1'b1; n++) @(posedge core_clk);
    bound(200);
    m.start_cond();
    m.send_byte(sel(1'b0, 1'b0), ack);
    m.stop_cond();
    want_ack("busy poll", 1'b0);
    for (n = 0; n < 40; n++)
    begin
      m.start_cond();
      m.send_byte(sel(1'b0, 1'b0), ack);
      m.stop_cond();
      if (ack === 1'b1)
        break;
    end
    bound(40);
  endtask
  // main sequence
  initial
  begin
    // x to low is an edge, so every asynchronous reset fires at time zero
    rst_n <= 1'b0;
    @(posedge core_clk);
    {cs_hi, cs_lo} <= 2'($random(seed));
    repeat (9) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // wrong type first, then every strap code
    for (int i = 4; i >= 0; i--)
    begin
      m.start_cond();
      m.send_byte(i < 4 ? {TYP, 2'(i), 2'b00} : {~TYP, cs_hi, cs_lo, 2'b00}, ack);
      m.stop_cond();
      want_ack("strap select", i < 4 && 2'(i) == {cs_hi, cs_lo});
    end
    // full page from a random offset wraps inside the page
    base = {5'h1F, 4'($random(seed))};
    open_w(base);
    for (int i = 0; i < 16; i++)
    begin
      a = {base[8:4], base[3:0] + 4'(i)};
      exp_mem[a] = 8'($random(seed));
      m.send_byte(exp_mem[a], ack);
      want_ack("page data", 1'b1);
    end
    m.stop_cond();
    wait_write();
    // guard high still lets the lower half be written
    @(posedge core_clk);
    guard <= 1'b1;
    open_w(9'h000);
    exp_mem[0] = 8'($random(seed));
    m.send_byte(exp_mem[0], ack);
    want_ack("lower data", 1'b1);
    m.stop_cond();
    wait_write();
    // guarded upper half: data refused, no write launched
    open_w(base);
    repeat (2)
    begin
      m.send_byte(~exp_mem[base], ack);
      want_ack("guarded data", 1'b0);
    end
    m.stop_cond();
    repeat (100) @(posedge core_clk) check("busy", {7'h00, write_busy}, 8'h00);
    // random read across the top, then current read after wrap
    open_w(9'h1FE);
    m.start_cond();
    m.send_byte(sel(1'b1, 1'b1), ack);
    want_ack("read select", 1'b1);
    rd_chk(9'h1FE, 1'b1);
    rd_chk(9'h1FF, 1'b0);
    m.stop_cond();
    m.start_cond();
    m.send_byte(sel(1'b0, 1'b1), ack);
    want_ack("current select", 1'b1);
    rd_chk(9'h000, 1'b0);
    m.stop_cond();
    // reset in mid-run: bus ignored while held
    @(posedge core_clk);
    rst_n <= 1'b0;
    m.start_cond();
    m.send_byte(sel(1'b0, 1'b0), ack);
    m.stop_cond();
    want_ack("select in reset", 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // wrong type warms the strap filter, then the guarded byte is read back
    m.start_cond();
    m.send_byte(8'h00, ack);
    m.stop_cond();
    want_ack("wrong type", 1'b0);
    open_w(base);
    m.start_cond();
    m.send_byte(sel(1'b1, 1'b1), ack);
    want_ack("reread select", 1'b1);
    rd_chk(base, 1'b0);
    m.stop_cond();
    tally_and_finish();
  end
endmodule // eep_top_test
